/* File: rtl/pmt_regs.svh */
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

// Contract
// - Count up, wrap after period, pulse match.
// - Period resets to FFh, software reads/writes.
// - Count resets to zero, software reads/writes.
// - Prescale 1, 4 or 16 of instruction clock.
// - Postscale ratio is field value plus one.
// - Postscaler completion sets the match flag.
// - Count or control write clears both scalers.
// - Control write leaves the count unchanged.
// - Timer runs only while the on bit is set.
// - Match pulse drives the serial shift clock.
// - Count and match feed the PWM time base.

// -----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------------
`define PMT_IDX_INT_CTL    8'h0b
`define PMT_IDX_FLAGS      8'h0c
`define PMT_IDX_FLAG_CLR   8'h0d
`define PMT_IDX_COUNT      8'h11
`define PMT_IDX_CONTROL    8'h12
`define PMT_IDX_ENABLES    8'h8c
`define PMT_IDX_PERIOD     8'h92

// -----------------------------------------------------------------------
// Bus geometry
// -----------------------------------------------------------------------
`define PMT_ADR_W          10
`define PMT_IDX_LSB        2

// -----------------------------------------------------------------------
// Reset values and masks
// -----------------------------------------------------------------------
`define PMT_RST_ZERO       8'h00
`define PMT_RST_PERIOD     8'hff
`define PMT_CTL_MASK       8'h7f
`define PMT_FLAG_MASK      8'h02

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define PMT_CTL_PRE_LO     0
`define PMT_CTL_PRE_HI     1
`define PMT_CTL_ON         2
`define PMT_CTL_POST_LO    3
`define PMT_CTL_POST_HI    6
`define PMT_FLAG_MATCH     1

// -----------------------------------------------------------------------
// Timing counts
// -----------------------------------------------------------------------
`define PMT_INSTR_DIV      4
`define PMT_PRE_LIM_1      4'h0
`define PMT_PRE_LIM_4      4'h3
`define PMT_PRE_LIM_16     4'hf

`endif

/* File: rtl/pmt_pkg.sv */
// -----------------------------------------------------------------------
// Shared types of the period match timer
// -----------------------------------------------------------------------
package pmt_pkg;

   // Handshake state of the register bus slave.
   typedef enum logic {
      PMT_BUS_IDLE,
      PMT_BUS_ACK
   } pmt_bus_state_t;

   // One register byte.
   typedef logic [7:0] pmt_byte_t;

endpackage : pmt_pkg

/* File: rtl/pmt_scale_if.sv */
`timescale 1ns/100ps
// -----------------------------------------------------------------------
// Links between the timer core and its two scalers
// -----------------------------------------------------------------------
interface pmt_scale_if;
   logic       clear;           // Clears both scaler counters.
   logic       run;             // Timer on bit.
   logic [1:0] prescaleSelect;  // Prescale ratio select.
   logic       prescaleTick;    // One pulse per prescaled tick.
   logic       matchPulse;      // Period match, before postscale.
   logic [3:0] postscaleSelect; // Postscale ratio minus one.
   logic       postscaleDone;   // One pulse per completed postscale.

   modport ctrl (output clear, run, prescaleSelect, matchPulse,
                 output postscaleSelect,
                 input  prescaleTick, postscaleDone);
   modport pre  (input  clear, run, prescaleSelect,
                 output prescaleTick);
   modport post (input  clear, run, matchPulse, postscaleSelect,
                 output postscaleDone);
endinterface : pmt_scale_if

/* File: rtl/pmt_prescaler.sv */
`timescale 1ns/100ps
`include "pmt_regs.svh"
// -----------------------------------------------------------------------
// Instruction clock divider and selectable prescaler
// -----------------------------------------------------------------------
module pmt_prescaler #(
   parameter int INSTR_DIV = `PMT_INSTR_DIV
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic resetn,
   // Scaler link.
   pmt_scale_if.pre scale
);
   localparam int IW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

   generate
      if (INSTR_DIV < 2) begin : badDiv
         $error("pmt_prescaler: INSTR_DIV must be at least 2");
      end
   endgenerate

   logic [IW-1:0] instrCnt_q;  // Oscillator phase within one cycle.
   logic [3:0]    preCnt_q;    // Prescaler count.
   logic [3:0]    preLimit;    // Last count of the selected ratio.
   logic          instrTick;   // Once per instruction cycle.
   logic          tick_q;      // Registered prescaled tick.

   assign instrTick          = (instrCnt_q == IW'(INSTR_DIV - 1));
   assign scale.prescaleTick = tick_q;

   // The instruction clock is free running; only the prescaler stops.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         instrCnt_q <= '0;
      end else if (instrTick) begin
         instrCnt_q <= '0;
      end else begin
         instrCnt_q <= instrCnt_q + 1'b1;
      end
   end

   // Ratio decode; both codes with the high bit set mean sixteen.
   always_comb begin
      case (scale.prescaleSelect)
         2'h0:    preLimit = `PMT_PRE_LIM_1;
         2'h1:    preLimit = `PMT_PRE_LIM_4;
         default: preLimit = `PMT_PRE_LIM_16;
      endcase
   end

   // Clear beats everything; a switched off timer keeps its count.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         preCnt_q <= 4'h0;
         tick_q   <= 1'b0;
      end else if (scale.clear) begin
         preCnt_q <= 4'h0;
         tick_q   <= 1'b0;
      end else if (scale.run && instrTick) begin
         tick_q   <= (preCnt_q >= preLimit);
         preCnt_q <= (preCnt_q >= preLimit) ? 4'h0 : preCnt_q + 4'h1;
      end else begin
         tick_q   <= 1'b0;
      end
   end

   prescaler_clear_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      scale.clear |=> (preCnt_q == 4'h0) && !tick_q)
      else $error("prescaler not cleared");

   prescaler_hold_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      !scale.run && !scale.clear |=> $stable(preCnt_q))
      else $error("prescaler moved while off");

endmodule : pmt_prescaler

/* File: rtl/pmt_postscaler.sv */
`timescale 1ns/100ps
`include "pmt_regs.svh"
// -----------------------------------------------------------------------
// Match postscaler
// -----------------------------------------------------------------------
module pmt_postscaler (
   // Clock and reset.
   input wire logic mclk,
   input wire logic resetn,
   // Scaler link.
   pmt_scale_if.post scale
);
   logic [3:0] postCnt_q; // Matches seen in this round.
   logic       done_q;    // Registered completion pulse.

   assign scale.postscaleDone = done_q;

   // Matches only arrive while running, so the count freezes when off.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         postCnt_q <= 4'h0;
         done_q    <= 1'b0;
      end else if (scale.clear) begin
         postCnt_q <= 4'h0;
         done_q    <= 1'b0;
      end else if (scale.matchPulse && scale.run) begin
         done_q    <= (postCnt_q >= scale.postscaleSelect);
         postCnt_q <= (postCnt_q >= scale.postscaleSelect) ? 4'h0
                      : postCnt_q + 4'h1;
      end else begin
         done_q    <= 1'b0;
      end
   end

   postscale_ratio_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      done_q |-> $past(postCnt_q) == $past(scale.postscaleSelect))
      else $error("postscale fired at wrong count");

endmodule : pmt_postscaler

/* File: rtl/pmt_timer_top.sv */
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "pmt_regs.svh"
// -----------------------------------------------------------------------
// Period match timer with Wishbone register slave
// -----------------------------------------------------------------------
module pmt_timer_top #(
   parameter int ADR_W = `PMT_ADR_W
) (
   // Clock and reset.
   input  wire logic             mclk,
   input  wire logic             resetn,
   // Wishbone classic slave.
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output      logic [31:0]      wb_dat_o,
   output      logic             wb_ack_o,
   // Interrupt.
   output      logic             irq,
   // Serial port shift clock source.
   output      logic             shiftClkSrc,
   // PWM time base.
   output      logic [7:0]       pwmCount,
   output      logic             pwmMatch
);

   // -------------------------------------------------------------------
   // Parameter checks
   // -------------------------------------------------------------------
   // The highest register index needs ten byte address bits.
   generate
      if (ADR_W < `PMT_ADR_W) begin : badAdr
         $error("pmt_timer_top: ADR_W too narrow for the register map");
      end
   endgenerate

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   pmt_pkg::pmt_bus_state_t busState_q;  // Slave handshake state.
   logic                    ack_q;       // Registered acknowledge.
   logic [31:0]             datO_q;      // Registered read data.
   logic                    busReq;      // New request this cycle.
   logic                    busWrite;    // Low byte write this cycle.
   logic [7:0]              regIdx;      // Register index of request.
   pmt_pkg::pmt_byte_t      wrByte;      // Low write data byte.
   pmt_pkg::pmt_byte_t      rdByte;      // Read mux output.

   pmt_pkg::pmt_byte_t      count_q;     // Timer count.
   pmt_pkg::pmt_byte_t      period_q;    // Period value.
   pmt_pkg::pmt_byte_t      control_q;   // Timer control.
   pmt_pkg::pmt_byte_t      intCtl_q;    // Interrupt control storage.
   pmt_pkg::pmt_byte_t      flags_q;     // Sticky peripheral flags.
   pmt_pkg::pmt_byte_t      enables_q;   // Peripheral interrupt enables.
   logic                    match_q;     // Period match pulse.
   logic                    irq_q;       // Registered interrupt line.

   logic                    wrCount;     // Software writes the count.
   logic                    wrControl;   // Software writes the control.
   logic                    wrPeriod;    // Software writes the period.
   logic                    wrFlagClr;   // Software clears flags.
   logic                    timerOn;     // Timer on bit.
   logic                    stepTick;    // Count advances this cycle.
   logic                    atPeriod;    // Count equals the period.
   pmt_pkg::pmt_byte_t      flagSet;     // Hardware flag events.
   pmt_pkg::pmt_byte_t      flagClr;     // Software flag clears.

   pmt_scale_if scale ();                // Link to the scalers.

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   // A request is taken once, in the cycle before ack rises; the
   // held request during the ack cycle is not taken a second time.
   assign busReq   = wb_cyc_i && wb_stb_i && !ack_q;
   assign busWrite = busReq && wb_we_i && wb_sel_i[0];
   assign regIdx   = wb_adr_i[`PMT_IDX_LSB +: 8];
   assign wrByte   = wb_dat_i[7:0];

   assign wrCount   = busWrite && (regIdx == `PMT_IDX_COUNT);
   assign wrControl = busWrite && (regIdx == `PMT_IDX_CONTROL);
   assign wrPeriod  = busWrite && (regIdx == `PMT_IDX_PERIOD);
   assign wrFlagClr = busWrite && (regIdx == `PMT_IDX_FLAG_CLR);

   // Read mux; unmapped and write only indices read as zero.
   always_comb begin
      case (regIdx)
         `PMT_IDX_INT_CTL: rdByte = intCtl_q;
         `PMT_IDX_FLAGS:   rdByte = flags_q;
         `PMT_IDX_COUNT:   rdByte = count_q;
         `PMT_IDX_CONTROL: rdByte = control_q;
         `PMT_IDX_ENABLES: rdByte = enables_q;
         `PMT_IDX_PERIOD:  rdByte = period_q;
         default:          rdByte = `PMT_RST_ZERO;
      endcase
   end

   // -------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------
   // Ack follows one cycle after a request and drops the cycle after.
   // Every address is answered so a stray access cannot hang the bus.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busState_q <= pmt_pkg::PMT_BUS_IDLE;
         ack_q      <= 1'b0;
      end else begin
         case (busState_q)
            pmt_pkg::PMT_BUS_IDLE: begin
               if (busReq) begin
                  busState_q <= pmt_pkg::PMT_BUS_ACK;
                  ack_q      <= 1'b1;
               end
            end
            pmt_pkg::PMT_BUS_ACK: begin
               busState_q <= pmt_pkg::PMT_BUS_IDLE;
               ack_q      <= 1'b0;
            end
            default: begin
               busState_q <= pmt_pkg::PMT_BUS_IDLE;
               ack_q      <= 1'b0;
            end
         endcase
      end
   end

   // Read data is captured with the request and held with ack.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         datO_q <= 32'h0000_0000;
      end else if (busReq && !wb_we_i) begin
         datO_q <= {24'h00_0000, rdByte};
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = datO_q;

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   // Period register; software may change it while the timer runs.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         period_q <= `PMT_RST_PERIOD;
      end else if (wrPeriod) begin
         period_q <= wrByte;
      end
   end

   // Control register; bit 7 is not stored and reads as zero.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         control_q <= `PMT_RST_ZERO;
      end else if (wrControl) begin
         control_q <= wrByte & `PMT_CTL_MASK;
      end
   end

   // Interrupt control is kept as plain storage; the global gating
   // that it configures lives outside this block.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         intCtl_q <= `PMT_RST_ZERO;
      end else if (busWrite && (regIdx == `PMT_IDX_INT_CTL)) begin
         intCtl_q <= wrByte;
      end
   end

   // Interrupt enables.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         enables_q <= `PMT_RST_ZERO;
      end else if (busWrite && (regIdx == `PMT_IDX_ENABLES)) begin
         enables_q <= wrByte;
      end
   end

   // -------------------------------------------------------------------
   // Scaler link
   // -------------------------------------------------------------------
   assign timerOn               = control_q[`PMT_CTL_ON];
   assign scale.clear           = wrCount || wrControl;
   assign scale.run             = timerOn;
   assign scale.prescaleSelect  =
      control_q[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO];
   assign scale.postscaleSelect =
      control_q[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO];
   assign scale.matchPulse      = match_q;

   pmt_prescaler #(
      .INSTR_DIV (`PMT_INSTR_DIV)
   ) uPrescaler (
      .mclk   (mclk),
      .resetn (resetn),
      .scale  (scale)
   );

   pmt_postscaler uPostscaler (
      .mclk   (mclk),
      .resetn (resetn),
      .scale  (scale)
   );

   // -------------------------------------------------------------------
   // Timer count
   // -------------------------------------------------------------------
   // A tick left over from the cycle the timer was switched off is
   // masked here, so no tick moves the count while off.
   // A control write restarts the prescaler, so a tick that lands in
   // the same cycle is dropped with it and the count stays put.
   assign stepTick = scale.prescaleTick && timerOn && !wrControl;
   assign atPeriod = (count_q == period_q);

   // A software write wins over a tick in the same cycle. The control
   // write path does not touch the count at all.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_q <= `PMT_RST_ZERO;
      end else if (wrCount) begin
         count_q <= wrByte;
      end else if (stepTick) begin
         if (atPeriod) begin
            count_q <= `PMT_RST_ZERO;
         end else begin
            count_q <= count_q + 8'h01;
         end
      end
   end

   // Match pulse on the wrapping tick; a period of zero matches on
   // every tick.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         match_q <= 1'b0;
      end else begin
         match_q <= stepTick && atPeriod && !wrCount;
      end
   end

   assign shiftClkSrc = match_q;
   assign pwmMatch    = match_q;
   assign pwmCount    = count_q;

   // -------------------------------------------------------------------
   // Flags and interrupt
   // -------------------------------------------------------------------
   assign flagSet = {6'h00, scale.postscaleDone, 1'b0};
   assign flagClr = wrFlagClr ? wrByte : `PMT_RST_ZERO;

   // Set wins over a clear in the same cycle, so no event is lost.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flags_q <= `PMT_RST_ZERO;
      end else begin
         flags_q <= ((flags_q & ~flagClr) | flagSet) & `PMT_FLAG_MASK;
      end
   end

   // Level interrupt, one cycle behind the flags.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & enables_q);
      end
   end

   assign irq = irq_q;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   count_wrap_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      stepTick && atPeriod && !wrCount
      |=> (count_q == 8'h00) && match_q)
      else $error("count did not wrap with a match pulse");

   count_step_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      stepTick && !atPeriod && !wrCount
      |=> (count_q == $past(count_q) + 8'h01) && !match_q)
      else $error("count did not step by one");

   period_write_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      wrPeriod |=> period_q == $past(wrByte))
      else $error("period write lost");

   count_write_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      wrCount |=> (count_q == $past(wrByte)) ##1 (count_q == $past(count_q)
      || !timerOn || scale.prescaleTick || $past(wrCount)))
      else $error("count write lost");

   count_keep_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      wrControl |=> $stable(count_q))
      else $error("control write changed the count");

   timer_off_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      !timerOn && !wrCount |=> $stable(count_q) && !match_q)
      else $error("count moved while off");

   shift_src_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      shiftClkSrc |-> (count_q == 8'h00) && pwmMatch)
      else $error("shift clock source without wrap");

   flag_set_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      scale.postscaleDone |=> flags_q[`PMT_FLAG_MATCH] ##1 1'b1)
      else $error("match flag not set");

   irq_level_a: assert property (@(posedge mclk) disable iff (!resetn)
      flags_q[`PMT_FLAG_MATCH] && enables_q[`PMT_FLAG_MATCH] |=> irq_q)
      else $error("interrupt not raised");

   // The line must fall again once no enabled flag is left.
   irq_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
      !(|(flags_q & enables_q)) |=> !irq_q)
      else $error("interrupt raised without an enabled flag");

   // The flag is sticky: only a software clear may take it away.
   flag_sticky_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      flags_q[`PMT_FLAG_MATCH] && !wrFlagClr |=> flags_q[`PMT_FLAG_MATCH])
      else $error("match flag dropped without a clear");

   // A clear with no event in the same cycle empties the flag.
   flag_clear_a: assert property (
      @(posedge mclk) disable iff (!resetn)
      wrFlagClr && wrByte[`PMT_FLAG_MATCH] && !scale.postscaleDone
      |=> !flags_q[`PMT_FLAG_MATCH])
      else $error("match flag clear lost");

   // Every taken request gets exactly one cycle of acknowledge.
   ack_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
      busReq |=> ack_q ##1 !ack_q)
      else $error("acknowledge not a single pulse");

endmodule : pmt_timer_top

/* File: tb/tb_pmt_timer_top.sv */
`timescale 1ns/100ps
`include "pmt_regs.svh"
// ---------------------------------------------------------------
// Self-checking bench of the period match timer.
// ---------------------------------------------------------------
module tb_pmt_timer_top;
   logic        mclk   = 1'b0;   // 20 MHz system clock.
   logic        resetn = 1'b0;   // Asynchronous reset, active low.
   logic        wbCyc  = 1'b0;   // Bus cycle.
   logic        wbStb  = 1'b0;   // Bus strobe.
   logic        wbWe   = 1'b0;   // Write enable.
   logic [9:0]  wbAdr  = 10'h000; // Byte address.
   logic [31:0] wbWdat = 32'h0;  // Write data.
   logic [31:0] wbRdat;          // Read data.
   logic        wbAck;           // Bus answer.
   logic        irq;             // Level interrupt.
   logic        shiftClk;        // Match pulse to the serial port.
   logic [7:0]  pwmCount;        // Time base count.
   logic        pwmMatch;        // Time base match.
   int          failures = 0;    // Mismatches seen.
   int          n_checks = 0;    // Comparisons made.
   int          n;               // Measured cycles.
   pmt_pkg::pmt_byte_t q;        // Last byte read.

   always #25 mclk = ~mclk;

   pmt_timer_top uut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_sel_i(4'hf), .wb_dat_i(wbWdat), .wb_dat_o(wbRdat),
      .wb_ack_o(wbAck), .irq(irq), .shiftClkSrc(shiftClk),
      .pwmCount(pwmCount), .pwmMatch(pwmMatch));

   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   // Reports and counts one comparison.
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // One classic cycle, held until the answer is sampled.
   task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge mclk);
      wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= w;
      wbAdr <= {i, 2'b00}; wbWdat <= {24'h0, d};
      do @(posedge mclk); while (wbAck !== 1'b1);
      q = wbRdat[7:0];
      wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
   endtask : bus
   // Reads a register and compares its byte.
   task rdc(input logic [7:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      chk(q, e);
   endtask : rdc
   // Waits for the next match pulse; the bound catches a dead timer.
   task wmatch();
      n = 0;
      do begin @(posedge mclk); n++; end
      while (shiftClk !== 1'b1 && n < 9000);
   endtask : wmatch

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   // Values straight after reset.
   task t_reset();
      rdc(`PMT_IDX_PERIOD, 8'hff);
      rdc(`PMT_IDX_COUNT, 8'h00);
      rdc(`PMT_IDX_CONTROL, 8'h00);
      rdc(`PMT_IDX_FLAGS, 8'h00);
      rdc(`PMT_IDX_ENABLES, 8'h00);
      rdc(`PMT_IDX_INT_CTL, 8'h00);
      chk(irq, 1'b0);
   endtask : t_reset
   // Register access; the control write restarts the scalers, so
   // the count cannot move within the next 61 cycles.
   task t_rw();
      bus(1'b1, `PMT_IDX_PERIOD, 8'h03);
      rdc(`PMT_IDX_PERIOD, 8'h03);
      bus(1'b1, `PMT_IDX_COUNT, 8'ha5);
      rdc(`PMT_IDX_COUNT, 8'ha5);
      bus(1'b1, `PMT_IDX_CONTROL, 8'hff);
      rdc(`PMT_IDX_CONTROL, 8'h7f);
      rdc(`PMT_IDX_COUNT, 8'ha5);
      bus(1'b1, 8'h40, 8'h5a);
      rdc(8'h40, 8'h00);
      bus(1'b1, `PMT_IDX_CONTROL, 8'h00);
   endtask : t_rw
   // Match spacing for every prescale code, period 3.
   task t_pre();
      bus(1'b1, `PMT_IDX_COUNT, 8'h00);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, `PMT_IDX_CONTROL, 8'h04 | c[7:0]);
         wmatch();
         wmatch();
         chk(n, 16 * (c == 0 ? 1 : (c == 1 ? 4 : 16)));
         chk(pwmMatch, 1'b1);
      end
   endtask : t_pre
   // Postscaler ratio sets the flag and raises the interrupt.
   task t_post();
      int m;
      int k;
      logic [3:0] codes [3] = '{4'h0, 4'h3, 4'hf};
      bus(1'b1, `PMT_IDX_CONTROL, 8'h00);
      bus(1'b1, `PMT_IDX_ENABLES, 8'h02);
      foreach (codes[j]) begin
         bus(1'b1, `PMT_IDX_COUNT, 8'h00);
         bus(1'b1, `PMT_IDX_FLAG_CLR, 8'h02);
         // The line trails the flag by one cycle.
         @(posedge mclk);
         chk(irq, 1'b0);
         bus(1'b1, `PMT_IDX_CONTROL, {1'b0, codes[j], 3'h4});
         m = 0;
         k = 0;
         while (irq !== 1'b1 && k < 3000) begin
            @(posedge mclk);
            if (shiftClk === 1'b1) m++;
            k++;
         end
         chk(m, codes[j] + 1);
         bus(1'b1, `PMT_IDX_CONTROL, {1'b0, codes[j], 3'h0});
         rdc(`PMT_IDX_FLAGS, 8'h02);
      end
      // Masking drops the line; clearing drops the flag.
      bus(1'b1, `PMT_IDX_ENABLES, 8'h00);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      bus(1'b1, `PMT_IDX_FLAG_CLR, 8'h02);
      rdc(`PMT_IDX_FLAGS, 8'h00);
   endtask : t_post
   // Switching off holds the count; a control write keeps it.
   task t_off();
      pmt_pkg::pmt_byte_t a;
      bus(1'b1, `PMT_IDX_CONTROL, 8'h04);
      repeat (41) @(posedge mclk);
      bus(1'b1, `PMT_IDX_CONTROL, 8'h00);
      bus(1'b0, `PMT_IDX_COUNT, 8'h00);
      a = q;
      repeat (200) @(posedge mclk);
      rdc(`PMT_IDX_COUNT, a);
      bus(1'b1, `PMT_IDX_COUNT, 8'h05);
      bus(1'b1, `PMT_IDX_CONTROL, 8'h02);
      rdc(`PMT_IDX_COUNT, 8'h05);
      chk(pwmCount, 8'h05);
   endtask : t_off
   // A second reset in mid-run restores the reset values.
   task t_rst();
      bus(1'b1, `PMT_IDX_PERIOD, 8'h09);
      bus(1'b1, `PMT_IDX_CONTROL, 8'h04);
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      rdc(`PMT_IDX_PERIOD, 8'hff);
      rdc(`PMT_IDX_COUNT, 8'h00);
      rdc(`PMT_IDX_CONTROL, 8'h00);
   endtask : t_rst

   // ---------------------------------------------------------------
   // Verdict, sequence and watchdog.
   // ---------------------------------------------------------------
   task stop_test();
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   // Main sequence; reset is held for 20 cycles first.
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_rw();
      t_pre();
      t_post();
      t_off();
      t_rst();
      stop_test();
   end

   // The run needs about 2000 cycles; 40000 means a hang.
   initial begin
      #2_000_000;
      failures++;
      stop_test();
   end
endmodule : tb_pmt_timer_top
